// >>> scix_core.sv
// Purpose: Switch core INTx aggregation, message generation and UR handling
// Assumes: All inputs come from logic on i_sys_clk
// Notes: Registers on a plain strobe port, read data one cycle late
// What this block does
// [RQ1] Keep readable per-line and per-port INTx aggregates
// [RQ2] Negated to asserted sends Assert_INTx upstream
// [RQ3] Asserted to negated sends Deassert_INTx upstream
// [RQ4] Aggregate port B and port C plus internal endpoint
// [RQ5] Downstream bridges pass interrupt lines unswizzled
// [RQ6] Upstream line y mixes B-y and rotated C
// [RQ7] NT external endpoint INTx messages leave on C
// [RQ8] DL_Down clears that port's virtual wires
// [RQ9] Overflowing UR completions dropped, status still kept
// [RQ10] Error messages may merge, never vanish
// [RQ11] Software must not starve a port
// [RQ12] Upstream type-0 configuration is UR
// [RQ13] Converted type-0 to nonzero device is UR
// [RQ14] Address-routed message before bridge init is UR
// [RQ15] TLP with no route through switch is UR
// [RQ16] Upstream address TLP to upstream port is UR
// [RQ17] TLP to disabled port is UR
// [RQ18] Unclaimed or enabled VGA region TLP is UR
// [RQ19] Downstream message to primary bus is UR
// [RQ20] Downstream configuration request is UR
// [RQ21] ID route to uninitialized port is UR
// [RQ22] Downstream broadcast-from-root TLP is UR
//
// Implementation choices: the address map and the address-and-strobe port.
`include "scix_defines.svh"
module scix_core #(
  parameter int CPL_DEPTH = 4 // UR completion slots, power of two
) (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rstn,
  // Register port
  input logic [7:0] i_reg_addr,
  input logic [31:0] i_reg_wdata,
  input logic i_reg_wr,
  input logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Downstream link state
  input logic i_b_dl_up,
  input logic i_c_dl_up,
  // Port B received INTx messages
  input logic i_b_int_valid,
  input logic i_b_int_assert,
  input logic [1:0] i_b_int_line,
  // Port C received INTx messages
  input logic i_c_int_valid,
  input logic i_c_int_assert,
  input logic [1:0] i_c_int_line,
  // Upstream INTx message out
  output logic o_up_int_valid,
  output logic o_up_int_assert,
  output logic [1:0] o_up_int_line,
  input logic i_up_int_ready,
  // NT external endpoint INTx in
  input logic i_nte_int_valid,
  input logic i_nte_int_assert,
  input logic [1:0] i_nte_int_line,
  output logic o_nte_int_ready,
  // Port C INTx message out
  output logic o_c_int_valid,
  output logic o_c_int_assert,
  output logic [1:0] o_c_int_line,
  input logic i_c_int_ready,
  // TLP descriptor to check
  input logic i_tlp_valid,
  input scix_pkg::scix_port_t i_tlp_port,
  input scix_pkg::scix_kind_t i_tlp_kind,
  input scix_pkg::scix_route_t i_tlp_route,
  input logic i_tlp_np,
  input logic [4:0] i_tlp_dev,
  input logic [7:0] i_tlp_bus,
  input logic i_tlp_hit_up,
  input logic i_tlp_hit_b,
  input logic i_tlp_hit_c,
  input logic i_tlp_dst_up,
  input logic i_tlp_vga,
  // UR verdict
  output logic o_ur_valid,
  output scix_pkg::scix_port_t o_ur_port,
  // UR completion request
  output logic o_cpl_valid,
  output scix_pkg::scix_port_t o_cpl_port,
  input logic i_cpl_ready,
  // Error message request
  output logic o_err_valid,
  input logic i_err_ready
);
  import scix_pkg::*;
  localparam int PW = $clog2(CPL_DEPTH); // Pointer width

  // Configuration and software state
  logic [12:0] ctrl_r; // Enables, init flags, NT mode
  logic [23:0] busn_r; // Primary and secondary bus numbers
  logic [3:0] ntint_r; // Internal NT endpoint interrupt lines
  // Interrupt virtual wires
  logic [3:0] b_wire_r; // Port B external lines
  logic [3:0] c_wire_r; // Port C external lines
  logic [3:0] b_prim; // Port B primary-side aggregate
  logic [3:0] c_prim; // Port C primary-side aggregate
  logic [3:0] up_agg; // Switch-wide aggregate
  // NT message holding stage
  logic c_valid_r;
  // UR pipeline
  logic ur_now; // Verdict for the current descriptor
  logic ur_r; // Registered verdict
  logic np_r; // Registered non-posted flag
  // UR completion FIFO
  scix_port_t cpl_mem [CPL_DEPTH]; // Ports owed a completion
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r; // Occupancy
  logic full;
  logic push;
  logic pop;
  logic want_cpl; // A completion is owed this cycle
  // Error reporting
  logic err_pend_r; // An error message is owed
  logic ur_sticky_r; // Sticky UR seen flag
  logic [7:0] ur_cnt_r; // Saturating UR count
  logic [7:0] drop_cnt_r; // Saturating dropped completion count
  logic sticky_clr; // Software clears the sticky flag
  logic [31:0] rd_nxt; // Read data before the output flop

  // Software writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ctrl_r <= 13'h0000;
      busn_r <= 24'h000000;
      ntint_r <= 4'h0;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `SCIX_A_CTRL: ctrl_r <= i_reg_wdata[12:0];
        `SCIX_A_BUS: busn_r <= i_reg_wdata[23:0];
        `SCIX_A_NTINT: ntint_r <= i_reg_wdata[3:0];
        default: begin
          // Read-only, unmapped or ERR: not stored here; an ERR write with bit 0 set clears the sticky flag below
        end
      endcase
    end
  end

  // Port B virtual wires
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      b_wire_r <= 4'h0;
    end else if (!i_b_dl_up) begin
      b_wire_r <= 4'h0; // RQ8
    end else if (i_b_int_valid) begin
      b_wire_r[i_b_int_line] <= i_b_int_assert;
    end
  end

  // Port C virtual wires
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      c_wire_r <= 4'h0;
    end else if (!i_c_dl_up) begin
      c_wire_r <= 4'h0; // RQ8
    end else if (i_c_int_valid) begin
      c_wire_r[i_c_int_line] <= i_c_int_assert;
    end
  end

  // Downstream bridges see device zero only, so no remapping
  assign b_prim = b_wire_r; // RQ5
  // Internal NT side shares port C's contribution
  assign c_prim = c_wire_r | ntint_r; // RQ4

  // Upstream bridge remap by device number
  for (genvar g = 0; g < `SCIX_NLINES; g++) begin : g_swz
    assign up_agg[g] = b_prim[g] | c_prim[(g + 3) % `SCIX_NLINES]; // RQ6
  end

  // Upstream message sequencer
  scix_intx_msg u_up_msg (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_agg(up_agg),
    .o_valid(o_up_int_valid),
    .o_assert(o_up_int_assert),
    .o_line(o_up_int_line),
    .i_ready(i_up_int_ready)
  );

  // NT external messages to port C in NT mode only
  // In transparent mode they are accepted and discarded
  assign o_nte_int_ready = !c_valid_r || i_c_int_ready;
  assign o_c_int_valid = c_valid_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      c_valid_r <= 1'b0;
      o_c_int_assert <= 1'b0;
      o_c_int_line <= 2'h0;
    end else if (o_nte_int_ready) begin
      c_valid_r <= i_nte_int_valid && ctrl_r[`SCIX_C_NT]; // RQ7
      if (i_nte_int_valid) begin
        o_c_int_assert <= i_nte_int_assert;
        o_c_int_line <= i_nte_int_line;
      end
    end
  end

  // TLP classifier
  scix_ur_check u_ur (
    .i_port(i_tlp_port),
    .i_kind(i_tlp_kind),
    .i_route(i_tlp_route),
    .i_dev(i_tlp_dev),
    .i_bus(i_tlp_bus),
    .i_hit_up(i_tlp_hit_up),
    .i_hit_b(i_tlp_hit_b),
    .i_hit_c(i_tlp_hit_c),
    .i_dst_up(i_tlp_dst_up),
    .i_vga(i_tlp_vga),
    .i_ctrl(ctrl_r),
    .i_busn(busn_r),
    .i_b_up(i_b_dl_up),
    .i_c_up(i_c_dl_up),
    .o_ur(ur_now)
  );

  // Verdict stage, one cycle after the descriptor
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ur_r <= 1'b0;
      np_r <= 1'b0;
      o_ur_port <= PORT_A;
    end else begin
      ur_r <= i_tlp_valid && ur_now;
      np_r <= i_tlp_np;
      if (i_tlp_valid) begin
        o_ur_port <= i_tlp_port;
      end
    end
  end
  assign o_ur_valid = ur_r;

  // Completion FIFO control; a full FIFO drops unless a pop frees a slot that cycle, counters still run
  assign want_cpl = ur_r && np_r; // RQ9
  assign full = (cnt_r == (PW+1)'(CPL_DEPTH));
  assign pop = (cnt_r != '0) && i_cpl_ready;
  assign push = want_cpl && (!full || pop); // RQ9
  assign o_cpl_valid = (cnt_r != '0);
  assign o_cpl_port = cpl_mem[rd_ptr_r];

  // Completion slot storage
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      cpl_mem[wr_ptr_r] <= o_ur_port;
    end
  end

  // Completion FIFO pointers and occupancy
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Error message owed; new errors merge into one pending message
  // A new error in the accept cycle keeps it pending, so none is lost
  assign o_err_valid = err_pend_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      err_pend_r <= 1'b0;
    end else if (ur_r) begin
      err_pend_r <= 1'b1; // RQ10
    end else if (i_err_ready) begin
      err_pend_r <= 1'b0;
    end
  end

  // Error status; updated whether or not a completion fits
  assign sticky_clr = i_reg_wr && (i_reg_addr == `SCIX_A_ERR)
                      && i_reg_wdata[`SCIX_E_UR];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ur_sticky_r <= 1'b0;
      ur_cnt_r <= 8'h00;
      drop_cnt_r <= 8'h00;
    end else begin
      if (ur_r) begin
        ur_sticky_r <= 1'b1; // RQ9
      end else if (sticky_clr) begin
        ur_sticky_r <= 1'b0;
      end
      if (ur_r && ur_cnt_r != `SCIX_CNT_MAX) begin
        ur_cnt_r <= ur_cnt_r + 8'h01;
      end
      if (want_cpl && !push && drop_cnt_r != `SCIX_CNT_MAX) begin
        drop_cnt_r <= drop_cnt_r + 8'h01; // RQ9
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (i_reg_addr)
      `SCIX_A_SWSTS: rd_nxt[3:0] = up_agg; // RQ1
      `SCIX_A_INTSTS: rd_nxt[11:0] = {c_prim, b_prim, up_agg}; // RQ1
      `SCIX_A_CTRL: rd_nxt[12:0] = ctrl_r;
      `SCIX_A_BUS: rd_nxt[23:0] = busn_r;
      `SCIX_A_NTINT: rd_nxt[3:0] = ntint_r;
      `SCIX_A_ERR: begin
        rd_nxt[`SCIX_E_UR] = ur_sticky_r;
        rd_nxt[`SCIX_F_URCNT] = ur_cnt_r;
        rd_nxt[`SCIX_F_DRCNT] = drop_cnt_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stands one cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_nxt;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : scix_core

// >>> scix_defines.svh
// Purpose: Constants for the switch core INTx and UR logic
// Assumes: Included by bare name after the package
// Notes: Register map and field positions
`ifndef SCIX_DEFINES_SVH
`define SCIX_DEFINES_SVH
`define SCIX_NLINES 4
`define SCIX_DEV0 5'h00
`define SCIX_CNT_MAX 8'hFF
`define SCIX_A_SWSTS 8'h00
`define SCIX_A_INTSTS 8'h04
`define SCIX_A_CTRL 8'h08
`define SCIX_A_BUS 8'h0C
`define SCIX_A_NTINT 8'h10
`define SCIX_A_ERR 8'h14
`define SCIX_C_NT 0
`define SCIX_C_UVGA 1
`define SCIX_C_UBME 2
`define SCIX_C_UINIT 3
`define SCIX_C_BMEM 4
`define SCIX_C_BIO 5
`define SCIX_C_BVGA 6
`define SCIX_C_BINIT 7
`define SCIX_C_CMEM 8
`define SCIX_C_CIO 9
`define SCIX_C_CVGA 10
`define SCIX_C_CINIT 11
`define SCIX_C_ENUM 12
`define SCIX_F_PRI 7:0
`define SCIX_F_BSEC 15:8
`define SCIX_F_CSEC 23:16
`define SCIX_E_UR 0
`define SCIX_F_URCNT 15:8
`define SCIX_F_DRCNT 23:16
`endif

// >>> scix_pkg.sv
// Purpose: Types shared by the switch core INTx and UR logic
// Assumes: Nothing
// Notes: Port, TLP kind and routing encodings
package scix_pkg;
  // Switch port of arrival
  typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C} scix_port_t;
  // TLP kind as seen by the core
  typedef enum logic [2:0] {K_MEM, K_IO, K_CFG0, K_CFG1, K_MSG, K_CPL} scix_kind_t;
  // Routing method
  typedef enum logic [2:0] {R_ADDR, R_ID, R_ROOT, R_BCAST, R_LOCAL} scix_route_t;
  // Message sequencer state
  typedef enum logic {S_IDLE, S_SEND} scix_state_t;
endpackage : scix_pkg

// >>> scix_intx_msg.sv
// Purpose: Turns aggregate INTx level changes into Assert/Deassert messages
// Assumes: Receiver takes a message when valid and ready are both high
// Notes: Level based; a change that reverts before it is captured is not reported
`include "scix_defines.svh"
module scix_intx_msg (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rstn,
  // Aggregate levels
  input logic [3:0] i_agg,
  // Message out
  output logic o_valid,
  output logic o_assert,
  output logic [1:0] o_line,
  input logic i_ready
);
  import scix_pkg::*;
  scix_state_t state_r; // Sequencer state
  logic [3:0] sent_r; // Level last reported upstream
  logic [3:0] pend; // Lines whose level differs from reported
  logic [1:0] pick; // Lowest pending line
  assign pend = i_agg ^ sent_r;
  // Lowest line wins so no line can be starved by a higher one
  always_comb begin
    pick = 2'h0;
    for (int i = `SCIX_NLINES - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 2'(i);
      end
    end
  end
  assign o_valid = (state_r == S_SEND);
  // Capture, then hold the message until accepted
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_r <= S_IDLE;
      sent_r <= 4'h0;
      o_assert <= 1'b0;
      o_line <= 2'h0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (|pend) begin
            o_line <= pick;
            o_assert <= i_agg[pick]; // RQ2
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          if (i_ready) begin
            sent_r[o_line] <= o_assert; // RQ3
            state_r <= S_IDLE;
          end
        end
      endcase
    end
  end
endmodule : scix_intx_msg

// >>> scix_ur_check.sv
// Purpose: Classifies one TLP descriptor as Unsupported Request or not
// Assumes: Window hits from address decoders
// Notes: Purely combinational
`include "scix_defines.svh"
module scix_ur_check (
  // TLP descriptor
  input scix_pkg::scix_port_t i_port,
  input scix_pkg::scix_kind_t i_kind,
  input scix_pkg::scix_route_t i_route,
  input logic [4:0] i_dev,
  input logic [7:0] i_bus,
  input logic i_hit_up,
  input logic i_hit_b,
  input logic i_hit_c,
  input logic i_dst_up,
  input logic i_vga,
  // Configuration and link state
  input logic [12:0] i_ctrl,
  input logic [23:0] i_busn,
  input logic i_b_up,
  input logic i_c_up,
  // Verdict
  output logic o_ur
);
  import scix_pkg::*;
  logic [7:0] pri, bsec, csec; // Bus numbers
  logic isid, tb, tc, tp, tu, nodn, amsg, off;
  // Port disabled: link down or decode enable for this kind clear
  function automatic logic port_off(input logic up, input logic mem, input logic io,
                                    input scix_kind_t k);
    port_off = !up || ((k == K_IO) ? !io : !mem);
  endfunction : port_off
  assign pri = i_busn[`SCIX_F_PRI];
  assign bsec = i_busn[`SCIX_F_BSEC];
  assign csec = i_busn[`SCIX_F_CSEC];
  assign isid = (i_route == R_ID);
  assign tb = isid ? (i_bus == bsec) : i_hit_b;
  assign tc = isid ? (i_bus == csec) : i_hit_c;
  assign tp = isid && (i_bus == pri);
  assign tu = isid ? !(tb || tc || tp) : !i_hit_up;
  assign nodn = !i_hit_b && !i_hit_c;
  assign amsg = (i_kind == K_MSG) && (i_route == R_ADDR);
  assign off = (tb && port_off(i_b_up, i_ctrl[`SCIX_C_BMEM], i_ctrl[`SCIX_C_BIO], i_kind))
            || (tc && port_off(i_c_up, i_ctrl[`SCIX_C_CMEM], i_ctrl[`SCIX_C_CIO], i_kind));
  // Completions are never judged here
  always_comb begin
    o_ur = 1'b0;
    if (i_kind == K_CPL) begin
      o_ur = 1'b0;
    end else if (i_port == PORT_A) begin
      o_ur = o_ur | (i_kind == K_CFG0); // RQ12
      o_ur = o_ur | ((i_kind == K_CFG1) && (tb || tc) && (i_dev != `SCIX_DEV0)); // RQ13
      o_ur = o_ur | (amsg && !i_ctrl[`SCIX_C_UINIT]); // RQ14
      o_ur = o_ur | ((i_route == R_ADDR) && i_hit_up && nodn); // RQ15
      o_ur = o_ur | ((i_route == R_ADDR || isid) && !tb && !tc); // RQ15
      o_ur = o_ur | ((i_route == R_ADDR) && i_dst_up); // RQ16
      o_ur = o_ur | off; // RQ17
      o_ur = o_ur | (i_vga && i_ctrl[`SCIX_C_UVGA] && !i_ctrl[`SCIX_C_BVGA]
                     && !i_ctrl[`SCIX_C_CVGA] && nodn); // RQ18
    end else begin
      o_ur = o_ur | (i_kind == K_CFG0) | (i_kind == K_CFG1); // RQ20
      o_ur = o_ur | (i_route == R_BCAST); // RQ22
      o_ur = o_ur | (amsg && !((i_port == PORT_B) ? i_ctrl[`SCIX_C_BINIT]
                                                  : i_ctrl[`SCIX_C_CINIT])); // RQ14
      o_ur = o_ur | ((i_route == R_ADDR) && i_hit_up && nodn); // RQ15
      o_ur = o_ur | ((i_kind == K_MSG) && tp && i_ctrl[`SCIX_C_ENUM]); // RQ19
      o_ur = o_ur | ((tb && bsec == pri) || (tc && csec == pri)); // RQ21
      o_ur = o_ur | off | (tu && !i_ctrl[`SCIX_C_UBME]); // RQ17
      o_ur = o_ur | (i_vga && ((i_hit_b && i_ctrl[`SCIX_C_BVGA])
                     || (i_hit_c && i_ctrl[`SCIX_C_CVGA]))); // RQ18
    end
  end
endmodule : scix_ur_check

// >>> scix_core_chk.sv
// Purpose: Port-level assertions for the switch core
// Assumes: One clock domain, synchronous active-low reset
// Notes: Sees only top ports
module scix_core_chk (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rstn,
  // Register port
  input logic i_reg_rd,
  input logic [31:0] o_reg_rdata,
  // Upstream and port C messages
  input logic o_up_int_valid,
  input logic o_up_int_assert,
  input logic [1:0] o_up_int_line,
  input logic i_up_int_ready,
  input logic o_c_int_valid,
  input logic [1:0] o_c_int_line,
  input logic i_c_int_ready,
  // Descriptor and verdict
  input logic i_tlp_valid,
  input scix_pkg::scix_port_t i_tlp_port,
  input scix_pkg::scix_kind_t i_tlp_kind,
  input scix_pkg::scix_route_t i_tlp_route,
  input logic i_tlp_np,
  input logic o_ur_valid,
  input scix_pkg::scix_port_t o_ur_port,
  input logic o_cpl_valid,
  input logic o_err_valid
);
  import scix_pkg::*;
  // One domain
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Read data only after a read
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("stray rdata");
  // Held while stalled
  up_hold_a: assert property (o_up_int_valid && !i_up_int_ready |=>
    o_up_int_valid && $stable({o_up_int_assert, o_up_int_line}))
    else $error("up msg unstable");
  up_gap_a: assert property (o_up_int_valid && i_up_int_ready |=> !o_up_int_valid)
    else $error("up valid stuck");
  c_hold_a: assert property (o_c_int_valid && !i_c_int_ready |=>
    o_c_int_valid && $stable(o_c_int_line))
    else $error("C msg unstable");
  ur_cause_a: assert property (o_ur_valid |-> $past(i_tlp_valid)
    && o_ur_port == $past(i_tlp_port))
    else $error("bad verdict");
  up_cfg0_a: assert property (i_tlp_valid && i_tlp_port == PORT_A
    && i_tlp_kind == K_CFG0 |=> o_ur_valid)
    else $error("up cfg0 passed");
  dn_cfg_a: assert property (i_tlp_valid && i_tlp_port != PORT_A
    && (i_tlp_kind inside {K_CFG0, K_CFG1}) |=> o_ur_valid)
    else $error("down cfg passed");
  dn_bcast_a: assert property (i_tlp_valid && i_tlp_port != PORT_A
    && i_tlp_route == R_BCAST |=> o_ur_valid)
    else $error("bcast passed");
  err_follow_a: assert property (o_ur_valid |=> o_err_valid)
    else $error("no error msg");
  // A full buffer still shows one
  cpl_follow_a: assert property (o_ur_valid && $past(i_tlp_np) |=> o_cpl_valid)
    else $error("no completion");
endmodule : scix_core_chk

bind scix_core scix_core_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_up_int_valid(o_up_int_valid), .o_up_int_assert(o_up_int_assert),
  .o_up_int_line(o_up_int_line), .i_up_int_ready(i_up_int_ready),
  .o_c_int_valid(o_c_int_valid), .o_c_int_line(o_c_int_line), .i_c_int_ready(i_c_int_ready),
  .i_tlp_valid(i_tlp_valid), .i_tlp_port(i_tlp_port), .i_tlp_kind(i_tlp_kind),
  .i_tlp_route(i_tlp_route), .i_tlp_np(i_tlp_np), .o_ur_valid(o_ur_valid),
  .o_ur_port(o_ur_port), .o_cpl_valid(o_cpl_valid), .o_err_valid(o_err_valid)
);

// >>> scix_far_model.sv
// Purpose: Far side sink
// Assumes: Ready changes only just after a clock edge
// Notes: Slow mode stalls every sink
module scix_far_model (
  // Clock and reset
  input logic i_sys_clk,
  input logic i_rstn,
  // Stall request
  input logic i_slow,
  // Ready lines
  output logic o_up_ready,
  output logic o_c_ready,
  output logic o_cpl_ready,
  output logic o_err_ready
);
  logic rdy_r; // Shared ready
  // Stalls end only when i_slow drops; all ports share one ready
  always_ff @(posedge i_sys_clk) begin
    rdy_r <= i_rstn & ~i_slow;
  end
  assign o_up_ready = rdy_r;
  assign o_c_ready = rdy_r;
  assign o_cpl_ready = rdy_r;
  assign o_err_ready = rdy_r;
endmodule : scix_far_model

// >>> test_switch_core_intx_and_ur_check.sv
// Purpose: Self-checking bench for the switch core
// Assumes: Far side model accepts at once unless slowed
// Notes: UR cases run from a table; INTx, overflow and reset by hand
`include "scix_defines.svh"
module test_switch_core_intx_and_ur_check;
  timeunit 1ns;
  timeprecision 1ps;
  import scix_pkg::*;
  // Descriptor and verdict
  typedef struct packed {
    scix_port_t p; scix_kind_t k; scix_route_t r; logic np; logic [4:0] dev;
    logic [7:0] bus; logic [2:0] hit; logic dup; logic vga; logic ur;
  } scix_row_t;
  logic clk, rstn, wr, rd, slow, b_up, c_up, t_v;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic b_v, b_a, c_v, c_a, n_v, n_a, up_v, up_a, up_rdy, n_rdy, co_v, co_a, co_rdy;
  logic [1:0] b_l, c_l, n_l, up_l, co_l, gl;
  logic ur_v, cpl_v, cpl_rdy, err_v, err_rdy;
  scix_port_t ur_p, cpl_p;
  scix_row_t t; // Descriptor being driven
  int num_errors, num_checks, ur_cnt, i;
  // Hit field is {upstream, B, C}; bus 02 is B, 03 is C, 01 primary
  scix_row_t rows [12] = '{
    '{PORT_A,K_CFG0,R_ID,1'b1,5'h00,8'h02,3'h0,1'b0,1'b0,1'b1},
    '{PORT_A,K_CFG1,R_ID,1'b1,5'h01,8'h02,3'h0,1'b0,1'b0,1'b1},
    '{PORT_A,K_CFG1,R_ID,1'b1,5'h00,8'h02,3'h0,1'b0,1'b0,1'b0},
    '{PORT_A,K_MEM,R_ADDR,1'b1,5'h00,8'h00,3'h6,1'b0,1'b0,1'b0},
    '{PORT_A,K_MEM,R_ADDR,1'b0,5'h00,8'h00,3'h4,1'b0,1'b0,1'b1},
    '{PORT_A,K_IO,R_ADDR,1'b1,5'h00,8'h00,3'h0,1'b1,1'b0,1'b1},
    '{PORT_A,K_MEM,R_ADDR,1'b1,5'h00,8'h00,3'h0,1'b0,1'b1,1'b1},
    '{PORT_B,K_CFG0,R_ID,1'b1,5'h00,8'h03,3'h0,1'b0,1'b0,1'b1},
    '{PORT_C,K_MSG,R_BCAST,1'b0,5'h00,8'h00,3'h0,1'b0,1'b0,1'b1},
    '{PORT_B,K_MSG,R_ID,1'b0,5'h00,8'h01,3'h0,1'b0,1'b0,1'b1},
    '{PORT_B,K_MEM,R_ADDR,1'b1,5'h00,8'h00,3'h0,1'b0,1'b0,1'b0},
    '{PORT_C,K_CPL,R_ID,1'b0,5'h00,8'h00,3'h0,1'b0,1'b0,1'b0}};
  scix_core #(.CPL_DEPTH(4)) uut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_b_dl_up(b_up), .i_c_dl_up(c_up),
    .i_b_int_valid(b_v), .i_b_int_assert(b_a), .i_b_int_line(b_l),
    .i_c_int_valid(c_v), .i_c_int_assert(c_a), .i_c_int_line(c_l),
    .o_up_int_valid(up_v), .o_up_int_assert(up_a), .o_up_int_line(up_l),
    .i_up_int_ready(up_rdy), .i_nte_int_valid(n_v), .i_nte_int_assert(n_a),
    .i_nte_int_line(n_l), .o_nte_int_ready(n_rdy), .o_c_int_valid(co_v),
    .o_c_int_assert(co_a), .o_c_int_line(co_l), .i_c_int_ready(co_rdy),
    .i_tlp_valid(t_v), .i_tlp_port(t.p), .i_tlp_kind(t.k), .i_tlp_route(t.r),
    .i_tlp_np(t.np), .i_tlp_dev(t.dev), .i_tlp_bus(t.bus), .i_tlp_hit_up(t.hit[2]),
    .i_tlp_hit_b(t.hit[1]), .i_tlp_hit_c(t.hit[0]), .i_tlp_dst_up(t.dup),
    .i_tlp_vga(t.vga), .o_ur_valid(ur_v), .o_ur_port(ur_p), .o_cpl_valid(cpl_v),
    .o_cpl_port(cpl_p), .i_cpl_ready(cpl_rdy), .o_err_valid(err_v), .i_err_ready(err_rdy));
  scix_far_model u_far (
    .i_sys_clk(clk), .i_rstn(rstn), .i_slow(slow), .o_up_ready(up_rdy),
    .o_c_ready(co_rdy), .o_cpl_ready(cpl_rdy), .o_err_ready(err_rdy));
  // Compare and count
  task automatic check(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // One-cycle register strobes
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdata;
  endtask : reg_rd
  task automatic send(input scix_row_t r);
    @(posedge clk);
    t <= r;
    t_v <= 1'b1;
    @(posedge clk);
    t_v <= 1'b0;
  endtask : send
  // INTx message from B (c low) or C
  task automatic intx(input logic c, input logic a, input logic [1:0] l);
    @(posedge clk);
    if (c) begin
      {c_v, c_a, c_l} <= {1'b1, a, l};
    end else begin
      {b_v, b_a, b_l} <= {1'b1, a, l};
    end
    @(posedge clk);
    b_v <= 1'b0;
    c_v <= 1'b0;
  endtask : intx
  // Bounded wait for up message
  task automatic wait_up();
    int k;
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      if (up_v === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      close_out();
    end
  endtask : wait_up
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, slow, t_v, b_v, b_a, c_v, c_a, n_v, n_a} = '0;
    {b_l, c_l, n_l, addr, wdata} = '0;
    {b_up, c_up} = 2'b11;
    t = '0;
    {num_errors, num_checks, ur_cnt} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({up_v, co_v, ur_v, cpl_v, err_v}, 32'h0);
    reg_rd(`SCIX_A_CTRL);
    check(rv, 32'h0);
    // Bridges uninitialized
    send('{PORT_B, K_MSG, R_ADDR, 1'b0, 5'h00, 8'h00, 3'h4, 1'b0, 1'b0, 1'b1});
    ur_cnt++;
    @(negedge clk);
    check(ur_v, 1'b1);
    // Enable all; VGA upstream only
    reg_wr(`SCIX_A_CTRL, 32'h0000_1BBF);
    reg_wr(`SCIX_A_BUS, 32'h0003_0201);
    reg_wr(`SCIX_A_SWSTS, 32'h0000_000F);
    reg_rd(`SCIX_A_CTRL);
    check(rv, 32'h0000_1BBF);
    reg_rd(`SCIX_A_SWSTS);
    check(rv, 32'h0);
    reg_rd(8'h20);
    check(rv, 32'h0);
    foreach (rows[j]) begin
      send(rows[j]);
      ur_cnt += int'(rows[j].ur);
      @(negedge clk);
      check(ur_v, rows[j].ur);
      if (rows[j].ur) check(ur_p, rows[j].p);
      @(negedge clk);
      check(cpl_v, rows[j].ur & rows[j].np);
      if (cpl_v === 1'b1) check(cpl_p, rows[j].p);
      check(err_v, rows[j].ur);
    end
    // Each line of B and C
    for (i = 0; i < 8; i++) begin
      gl = i[1:0] + 2'(i[2]);
      intx(i[2], 1'b1, i[1:0]);
      wait_up();
      check(up_a, 1'b1);
      check(up_l, gl);
      reg_rd(`SCIX_A_SWSTS);
      check(rv, 32'h1 << gl);
      intx(i[2], 1'b0, i[1:0]);
      wait_up();
      check(up_a, 1'b0);
      check(up_l, gl);
    end
    // Link loss on port B
    intx(1'b0, 1'b1, 2'h2);
    wait_up();
    @(posedge clk);
    b_up <= 1'b0;
    wait_up();
    check({up_a, up_l}, 3'h2);
    send(rows[3]);
    ur_cnt++;
    @(negedge clk);
    check(ur_v, 1'b1);
    @(posedge clk) b_up <= 1'b1;
    // Internal endpoint line A
    reg_wr(`SCIX_A_NTINT, 32'h1);
    wait_up();
    check({up_a, up_l}, 3'h5);
    reg_rd(`SCIX_A_INTSTS);
    check(rv, 32'h0000_0102);
    reg_wr(`SCIX_A_NTINT, 32'h0);
    wait_up();
    check({up_a, up_l}, 3'h1);
    // External endpoint to C
    @(posedge clk);
    {n_v, n_a, n_l} <= {1'b1, 1'b1, 2'h3};
    @(posedge clk);
    n_v <= 1'b0;
    @(negedge clk);
    check({n_rdy, co_v, co_a, co_l}, 5'h1F);
    // Stalled: six refusals, four slots
    @(posedge clk);
    slow <= 1'b1;
    intx(1'b0, 1'b1, 2'h0);
    repeat (6) send(rows[0]);
    ur_cnt += 6;
    reg_rd(`SCIX_A_ERR);
    check(rv[23:0], {8'h02, 8'(ur_cnt), 8'h01});
    check({err_v, cpl_v, up_v}, 3'h7);
    @(posedge clk);
    slow <= 1'b0;
    for (i = 0; i < 20 && cpl_v !== 1'b0; i++) @(negedge clk);
    check({cpl_v, err_v}, 2'h0);
    reg_wr(`SCIX_A_ERR, 32'h1);
    reg_rd(`SCIX_A_ERR);
    check(rv[0], 1'b0);
    // Second reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(`SCIX_A_CTRL);
    check(rv, 32'h0);
    close_out();
  end
endmodule : test_switch_core_intx_and_ur_check
